/* detc_trigger_control.v */
// trigger control: two engines, combiner, scanning mode, timeout, arm, power
// assumes samples arrive registered on mclk; the external trigger pin and
// the start input are asynchronous and pass two flops; config levels are on mclk
`timescale 1ns/10ps
`include "detc_map.vh"
module detc_trigger_control #(
  parameter TICK_CYCLES = `DETC_TICK_CYCLES,
  parameter SINGLE_EXT_LEVEL = 1
) (
  input wire mclk,
  input wire srst,
  input wire [16*8-1:0] chanSamples,
  input wire [7:0] extSample,
  input wire [7:0] starSample,
  input wire extTrigPin,
  input wire [1:0] combineOp,
  input wire firstEngineId,
  input wire [8:0] firstSourceSelect,
  input wire [1:0] firstSlope,
  input wire [7:0] firstLevelCode,
  input wire secondEngineId,
  input wire [8:0] secondSourceSelect,
  input wire [1:0] secondSlope,
  input wire [7:0] secondLevelCode,
  input wire scanMode,
  input wire [1:0] scanSlope,
  input wire [7:0] scanLevelCode,
  input wire deferAcquisitionStart,
  input wire [31:0] timeoutTicks,
  input wire powerState,
  input wire startCapture,
  output reg triggerPulse,
  output reg autoTriggerPulse,
  output reg triggered,
  output reg armed,
  output reg acquiring,
  output reg adcPowerUp
);
  reg ext1_ff;
  reg ext2_ff;
  reg ext3_ff;
  reg start1_ff;
  reg start2_ff;
  reg start3_ff;
  reg waitExt_ff;
  reg [15:0] tickCnt_ff;
  reg [31:0] tickTotal_ff;
  reg [8:0] srcJ;
  reg [8:0] srcK;
  reg [1:0] slopeJ;
  reg [1:0] slopeK;
  reg [7:0] levelJ;
  reg [7:0] levelK;
  reg [1:0] effOp;
  reg [8:0] rawSrcJ;
  reg [8:0] rawSrcK;
  reg [1:0] rawSlopeJ;
  reg [1:0] rawSlopeK;
  reg [7:0] rawLevelJ;
  reg [7:0] rawLevelK;
  reg combinedEvent;
  reg timeoutHit;
  reg armEdge;
  wire eventJ;
  wire eventK;

  // map the two configuration slots onto engines by their engine code
  always @* begin
    if (firstEngineId == `DETC_ENG_SECOND && secondEngineId == `DETC_ENG_FIRST) begin
      rawSrcJ = secondSourceSelect;
      rawSlopeJ = secondSlope;
      rawLevelJ = secondLevelCode;
      rawSrcK = firstSourceSelect;
      rawSlopeK = firstSlope;
      rawLevelK = firstLevelCode;
    end else begin
      rawSrcJ = firstSourceSelect;
      rawSlopeJ = firstSlope;
      rawLevelJ = firstLevelCode;
      rawSrcK = secondSourceSelect;
      rawSlopeK = secondSlope;
      rawLevelK = secondLevelCode;
    end
  end

  // scanning overrides the dual setup; only one setup is meant to be used
  always @* begin
    srcJ = rawSrcJ;
    slopeJ = rawSlopeJ;
    levelJ = rawLevelJ;
    srcK = rawSrcK;
    slopeK = rawSlopeK;
    levelK = rawLevelK;
    effOp = combineOp;
    if (scanMode) begin
      effOp = `DETC_OP_FIRST;
      srcJ = `DETC_SRC_EXT;
      slopeJ = scanSlope;
      levelJ = scanLevelCode;
      srcK = `DETC_SRC_OFF;
    end
    // one external comparator: second level wins when both pick external
    if (SINGLE_EXT_LEVEL != 0 && srcJ == `DETC_SRC_EXT && srcK == `DETC_SRC_EXT) begin
      levelJ = levelK;
    end
  end

  // two independent engines with their own settings and outputs
  detc_engine engineJ (
    .mclk(mclk),
    .srst(srst),
    .chanSamples(chanSamples),
    .extSample(extSample),
    .starSample(starSample),
    .sourceSelect(srcJ),
    .slopeSelect(slopeJ),
    .levelCode(levelJ),
    .eventPulse(eventJ)
  );

  detc_engine engineK (
    .mclk(mclk),
    .srst(srst),
    .chanSamples(chanSamples),
    .extSample(extSample),
    .starSample(starSample),
    .sourceSelect(srcK),
    .slopeSelect(slopeK),
    .levelCode(levelK),
    .eventPulse(eventK)
  );

  // combiner; retired code 3 never reaches here in use and triggers nothing
  always @* begin
    case (effOp)
      `DETC_OP_FIRST: begin
        combinedEvent = eventJ;
      end
      `DETC_OP_SECOND: begin
        combinedEvent = eventK;
      end
      `DETC_OP_EITHER: begin
        combinedEvent = eventJ | eventK;
      end
      default: begin
        combinedEvent = 1'b0;
      end
    endcase
  end

  // pin and command synchronisers; third stage only feeds edge detect
  always @(posedge mclk) begin
    if (srst) begin
      ext1_ff <= 1'b0;
      ext2_ff <= 1'b0;
      ext3_ff <= 1'b0;
      start1_ff <= 1'b0;
      start2_ff <= 1'b0;
      start3_ff <= 1'b0;
    end else begin
      ext1_ff <= extTrigPin;
      ext2_ff <= ext1_ff;
      ext3_ff <= ext2_ff;
      start1_ff <= startCapture;
      start2_ff <= start1_ff;
      start3_ff <= start2_ff;
    end
  end

  always @* begin
    armEdge = start2_ff && !start3_ff;
    // timeout only while armed, acquiring and nonzero; at least, not equal,
    // so a timeout lowered below the ticks already elapsed still fires
    timeoutHit = armed && acquiring && (timeoutTicks != 32'h00000000) &&
                 (tickTotal_ff >= timeoutTicks - 32'h00000001) &&
                 (tickCnt_ff == TICK_CYCLES[15:0] - 16'h0001);
  end

  // arm, deferred start, timeout counting and triggered flag
  always @(posedge mclk) begin
    if (srst) begin
      armed <= 1'b0;
      acquiring <= 1'b0;
      waitExt_ff <= 1'b0;
      triggered <= 1'b0;
      triggerPulse <= 1'b0;
      autoTriggerPulse <= 1'b0;
      tickCnt_ff <= 16'h0000;
      tickTotal_ff <= 32'h00000000;
      adcPowerUp <= `DETC_PWR_OFF;
    end else begin
      adcPowerUp <= (powerState == `DETC_PWR_ON);
      triggerPulse <= 1'b0;
      autoTriggerPulse <= 1'b0;
      if (armEdge) begin
        armed <= 1'b1;
        triggered <= 1'b0;
        tickCnt_ff <= 16'h0000;
        tickTotal_ff <= 32'h00000000;
        // deferred start holds acquisition until the next external edge
        if (scanMode && deferAcquisitionStart == `DETC_DEFER_START) begin
          waitExt_ff <= 1'b1;
          acquiring <= 1'b0;
        end else begin
          waitExt_ff <= 1'b0;
          acquiring <= 1'b1;
        end
      end else if (armed && waitExt_ff) begin
        if (ext2_ff && !ext3_ff) begin
          waitExt_ff <= 1'b0;
          acquiring <= 1'b1;
        end
      end else if (armed && acquiring) begin
        if (combinedEvent || timeoutHit) begin
          triggerPulse <= 1'b1;
          autoTriggerPulse <= timeoutHit && !combinedEvent;
          triggered <= 1'b1;
          tickCnt_ff <= 16'h0000;
          tickTotal_ff <= 32'h00000000;
        end else if (tickCnt_ff == TICK_CYCLES[15:0] - 16'h0001) begin
          tickCnt_ff <= 16'h0000;
          tickTotal_ff <= tickTotal_ff + 32'h00000001;
        end else begin
          tickCnt_ff <= tickCnt_ff + 16'h0001;
        end
      end
    end
  end
endmodule

/* detc_map.vh */
// constants for the dual engine trigger control block
// assumes a 10 MHz mclk; included by the design files by bare name
// Operation
// - level is unsigned 8-bit code: 0 negative limit, 128 zero, 255 positive
// - single external comparator: both engines external, second level used for both
// - combine code 0 triggers on first engine only
// - combine code 1 triggers on second engine only
// - combine code 2 triggers on either engine
// - first engine is code 0, second engine is code 1
// - source decode: 0,1 A,B; 2 external; 3 off; 4..0x11 C..P; 0x100 star
// - slope code 1 flags samples rising above the level
// - slope code 2 flags samples falling below the level
// - two independent engines, each with own settings and event output
// - scanning mode forces first-engine-only with external source
// - scanning with defer option 1 waits for next external event after arming
// - automatic trigger after timeout counted in 10 us ticks
// - power code 0 powers converters down, code 1 powers them up
// - start-capture command arms the device, then acquisition follows trigger setup
// - triggered flag is 1 once a trigger occurred since last arm
`ifndef DETC_MAP_VH
`define DETC_MAP_VH
`define DETC_OP_FIRST 2'h0
`define DETC_OP_SECOND 2'h1
`define DETC_OP_EITHER 2'h2
`define DETC_ENG_FIRST 1'h0
`define DETC_ENG_SECOND 1'h1
`define DETC_SRC_CHAN_A 9'h000
`define DETC_SRC_CHAN_B 9'h001
`define DETC_SRC_EXT 9'h002
`define DETC_SRC_OFF 9'h003
`define DETC_SRC_CHAN_C 9'h004
`define DETC_SRC_CHAN_P 9'h011
`define DETC_SRC_STAR 9'h100
`define DETC_SLOPE_RISE 2'h1
`define DETC_SLOPE_FALL 2'h2
`define DETC_LEVEL_ZERO 8'h80
`define DETC_DEFER_START 1'h1
`define DETC_PWR_OFF 1'h0
`define DETC_PWR_ON 1'h1
`define DETC_TICK_NS 10000
`define DETC_CLK_NS 100
`define DETC_TICK_CYCLES (`DETC_TICK_NS / `DETC_CLK_NS)
`endif

/* detc_engine.v */
// one crossing detector: picks a source sample and compares it with a level
// assumes all sample inputs are on mclk and already registered
`timescale 1ns/10ps
`include "detc_map.vh"
module detc_engine (
  input wire mclk,
  input wire srst,
  input wire [16*8-1:0] chanSamples,
  input wire [7:0] extSample,
  input wire [7:0] starSample,
  input wire [8:0] sourceSelect,
  input wire [1:0] slopeSelect,
  input wire [7:0] levelCode,
  output reg eventPulse
);
  reg [7:0] sample;
  reg sampleValid;
  reg above_ff;
  reg primed_ff;
  reg nxtAbove;
  reg below_ff;
  reg nxtBelow;

  // source decode; channel C sits at code 4 so codes 2,3 are skipped
  always @* begin
    sampleValid = 1'b1;
    sample = 8'h00;
    if (sourceSelect == `DETC_SRC_CHAN_A || sourceSelect == `DETC_SRC_CHAN_B) begin
      sample = chanSamples[sourceSelect[0]*8 +: 8];
    end else if (sourceSelect == `DETC_SRC_EXT) begin
      sample = extSample;
    end else if (sourceSelect >= `DETC_SRC_CHAN_C && sourceSelect <= `DETC_SRC_CHAN_P) begin
      sample = chanSamples[(sourceSelect[4:0] - 5'h02)*8 +: 8];
    end else if (sourceSelect == `DETC_SRC_STAR) begin
      sample = starSample;
    end else begin
      sampleValid = 1'b0; // off and unknown codes never fire
    end
    // unsigned code compare: 0 negative limit, 128 zero, 255 positive
    nxtAbove = (sample > levelCode);
    // fall keeps its own side, so a sample resting on the level counts as neither above nor below
    nxtBelow = (sample < levelCode);
  end

  // crossing detect on the side change; first valid sample after reset or an off or unknown code only primes
  always @(posedge mclk) begin
    if (srst) begin
      above_ff <= 1'b0;
      below_ff <= 1'b0;
      primed_ff <= 1'b0;
      eventPulse <= 1'b0;
    end else begin
      above_ff <= nxtAbove;
      below_ff <= nxtBelow;
      primed_ff <= sampleValid;
      eventPulse <= 1'b0;
      if (sampleValid && primed_ff) begin
        if (slopeSelect == `DETC_SLOPE_RISE) begin
          eventPulse <= nxtAbove && !above_ff;
        end else if (slopeSelect == `DETC_SLOPE_FALL) begin
          eventPulse <= nxtBelow && !below_ff;
        end
      end
    end
  end
endmodule

/* detc_monitor.sv */
// checker for the trigger control outputs
// bound to every detc_trigger_control; sees its ports only
`timescale 1ns/10ps
module detc_monitor (
  input wire mclk,
  input wire srst,
  input wire extTrigPin,
  input wire [1:0] combineOp,
  input wire scanMode,
  input wire deferAcquisitionStart,
  input wire [31:0] timeoutTicks,
  input wire powerState,
  input wire startCapture,
  input wire triggerPulse,
  input wire autoTriggerPulse,
  input wire triggered,
  input wire armed,
  input wire acquiring,
  input wire adcPowerUp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // arming: a rise of the start level, then armed with a cleared flag
  // exactly three edges later (two sync flops plus the arm edge)
  sequence armRise;
    $rose(startCapture);
  endsequence
  sequence armSeen;
    ##3 (armed && !triggered);
  endsequence
  chk_arm_latency: assert property (armRise |-> armSeen)
    else $error("armed missing after start rise");
  // power output lags the request by one cycle
  chk_power_follow: assert property (!$past(srst) |-> adcPowerUp == $past(powerState))
    else $error("power output not following request");
  chk_flag_set: assert property (triggerPulse |-> triggered)
    else $error("trigger without status flag");
  chk_acq_gate: assert property (triggerPulse |-> $past(acquiring))
    else $error("trigger while not acquiring");
  chk_auto_marks: assert property (autoTriggerPulse |-> triggerPulse)
    else $error("auto trigger without board trigger");
  chk_zero_timeout: assert property (timeoutTicks == 32'h0 && $past(timeoutTicks) == 32'h0
    |-> !autoTriggerPulse)
    else $error("auto trigger with zero timeout");
  // deferral: acquisition may only open after the pin went high
  chk_defer_pin: assert property ($rose(acquiring) && scanMode && deferAcquisitionStart
    |-> $past(extTrigPin))
    else $error("deferred start without external edge");
  chk_retired_op: assert property (combineOp == 2'h3 && $past(combineOp, 2) == 2'h3
    && timeoutTicks == 32'h0 && !scanMode |-> !triggerPulse)
    else $error("trigger under retired combine code");
endmodule
bind detc_trigger_control detc_monitor detc_monitor_inst (.mclk(mclk), .srst(srst),
  .extTrigPin(extTrigPin), .combineOp(combineOp), .scanMode(scanMode),
  .deferAcquisitionStart(deferAcquisitionStart), .timeoutTicks(timeoutTicks),
  .powerState(powerState), .startCapture(startCapture), .triggerPulse(triggerPulse),
  .autoTriggerPulse(autoTriggerPulse), .triggered(triggered), .armed(armed),
  .acquiring(acquiring), .adcPowerUp(adcPowerUp));

/* detc_stream_model.sv */
// converter, external and star sample streams for the trigger bench
// one source carries the value; the rest rest at the negative limit
`timescale 1ns/10ps
module detc_stream_model (
  input wire mclk,
  input wire [8:0] srcCode,
  input wire [7:0] value,
  output reg [127:0] chanSamples,
  output reg [7:0] extSample,
  output reg [7:0] starSample
);
  integer i;
  // registered like the converters, so streams move only on mclk
  always @(posedge mclk) begin
    for (i = 0; i < 16; i = i + 1) begin
      chanSamples[i*8 +: 8] <= (srcCode == (i < 2 ? i : i + 2)) ? value : 8'h00;
    end
    extSample <= (srcCode == 9'h002) ? value : 8'h00;
    starSample <= (srcCode == 9'h100) ? value : 8'h00;
  end
endmodule

/* tb_top.sv */
// self-checking bench for the dual engine trigger control
// stream model feeds samples; expected triggers wait in a queue
`timescale 1ns/10ps
module tb_top;
  reg mclk, srst, extTrigPin, scanMode, deferAcquisitionStart, powerState, startCapture;
  reg firstEngineId, secondEngineId;
  reg [1:0] combineOp, firstSlope, secondSlope, scanSlope;
  reg [8:0] firstSourceSelect, secondSourceSelect, srcCode;
  reg [7:0] firstLevelCode, secondLevelCode, scanLevelCode, value, lvl;
  reg [31:0] timeoutTicks;
  wire [127:0] chanSamples;
  wire [7:0] extSample, starSample;
  wire triggerPulse, autoTriggerPulse, triggered, armed, acquiring, adcPowerUp;
  logic [8:0] codes [7] = '{9'h000, 9'h001, 9'h002, 9'h004, 9'h011, 9'h100, 9'h003};
  bit expq[$];
  integer fails, checkCount, k, op, e;
  detc_stream_model detc_stream_model_inst (.mclk(mclk), .srcCode(srcCode), .value(value),
    .chanSamples(chanSamples), .extSample(extSample), .starSample(starSample));
  detc_trigger_control #(.TICK_CYCLES(2), .SINGLE_EXT_LEVEL(1)) detc_trigger_control_inst (
    .mclk(mclk), .srst(srst), .chanSamples(chanSamples), .extSample(extSample),
    .starSample(starSample), .extTrigPin(extTrigPin), .combineOp(combineOp),
    .firstEngineId(firstEngineId), .firstSourceSelect(firstSourceSelect),
    .firstSlope(firstSlope), .firstLevelCode(firstLevelCode), .secondEngineId(secondEngineId),
    .secondSourceSelect(secondSourceSelect), .secondSlope(secondSlope),
    .secondLevelCode(secondLevelCode), .scanMode(scanMode), .scanSlope(scanSlope),
    .scanLevelCode(scanLevelCode), .deferAcquisitionStart(deferAcquisitionStart),
    .timeoutTicks(timeoutTicks), .powerState(powerState), .startCapture(startCapture),
    .triggerPulse(triggerPulse), .autoTriggerPulse(autoTriggerPulse), .triggered(triggered),
    .armed(armed), .acquiring(acquiring), .adcPowerUp(adcPowerUp));
  // 10 MHz sample clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task tick(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task cmp(input string what, input exp, input got);
    checkCount = checkCount + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task conclude;
    $display("checks %0d fails %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task bail(input ok);
    cmp("wait", 1'b1, ok);
    if (ok !== 1'b1) conclude;
  endtask
  // bounded wait until every noted trigger has shown up
  task drain;
    for (k = 0; k < 20 && expq.size() > 0; k++) tick(1);
    bail(expq.size() == 0);
  endtask
  task arm;
    startCapture <= 1'b0;
    tick(2);
    startCapture <= 1'b1;
    // armed only stands after two sync flops and the arm edge
    tick(4);
    bail(armed);
  endtask
  // park streams, configure, then one crossing on src; skew splits first level
  task try(input [1:0] o, input [8:0] s1, input [8:0] s2, input [1:0] sl, input [8:0] src,
    input [7:0] skew, input fire);
    lvl = 8'h01 + 8'($urandom % 254);
    srcCode <= 9'h003;
    // park first: new levels against a live stream could cross by themselves
    tick(2);
    {combineOp, firstSourceSelect, secondSourceSelect} <= {o, s1, s2};
    {firstSlope, secondSlope, scanSlope} <= {sl, sl, sl};
    {firstLevelCode, secondLevelCode, scanLevelCode} <= {lvl ^ skew, lvl, lvl};
    tick(4);
    srcCode <= src;
    value <= (sl == 2'h1) ? lvl - 8'h01 : lvl + 8'h01;
    tick(4);
    if (fire) expq.push_back(1'b0);
    value <= (sl == 2'h1) ? lvl + 8'h01 : lvl - 8'h01;
    tick(8);
    drain;
  endtask
  // each board trigger takes the oldest note; a trigger with none noted fails
  always @(posedge mclk) begin
    if (triggerPulse === 1'b1) begin
      if (expq.size() == 0) cmp("trigger", 1'b0, 1'b1);
      else cmp("auto", expq.pop_front(), autoTriggerPulse);
    end
  end
  initial begin
    {srst, extTrigPin, scanMode, deferAcquisitionStart, powerState, startCapture} = 6'h20;
    {combineOp, firstSourceSelect, secondSourceSelect, firstSlope, secondSlope} = 0;
    {scanSlope, firstLevelCode, secondLevelCode, scanLevelCode, timeoutTicks} = 0;
    {srcCode, value, firstEngineId, secondEngineId} = 19'h1;
    fails = 0;
    checkCount = 0;
    lvl = 8'($urandom(32'h9d6f));
    tick(2);
    srst <= 1'b0;
    tick(1);
    cmp("armed", 1'b0, armed);
    powerState <= 1'b1;
    tick(2);
    cmp("power", 1'b1, adcPowerUp);
    arm;
    for (op = 0; op < 4; op++) for (e = 0; e < 2; e++)
      try(op[1:0], 9'h000, 9'h004, 2'h1 + 2'(op[0] ^ e[0]), e ? 9'h004 : 9'h000, 8'h00,
        op == 2 || op == e);
    for (e = 0; e < 7; e++)
      try(2'h0, codes[e], 9'h003, 2'h1, codes[e] == 9'h003 ? 9'h000 : codes[e], 8'h00,
        codes[e] != 9'h003);
    try(2'h0, 9'h000, 9'h003, 2'h3, 9'h000, 8'h00, 1'b0);
    try(2'h0, 9'h002, 9'h002, 2'h1, 9'h002, 8'h40, 1'b1);
    {firstEngineId, secondEngineId} <= 2'h2;
    try(2'h0, 9'h000, 9'h001, 2'h1, 9'h001, 8'h00, 1'b1);
    try(2'h0, 9'h000, 9'h001, 2'h1, 9'h000, 8'h00, 1'b0);
    cmp("triggered", 1'b1, triggered);
    timeoutTicks <= 32'h3;
    expq.push_back(1'b1);
    drain;
    timeoutTicks <= 32'h0;
    arm;
    tick(2);
    cmp("rearm", 1'b0, triggered);
    srst <= 1'b1;
    startCapture <= 1'b0; // a level left high would arm again on release
    tick(2);
    cmp("reset", 1'b0, armed | triggered | acquiring);
    {srst, scanMode, deferAcquisitionStart} <= 3'h3;
    tick(2);
    arm;
    tick(6);
    cmp("deferred", 1'b0, acquiring);
    extTrigPin <= 1'b1;
    for (k = 0; k < 10 && acquiring !== 1'b1; k++) tick(1);
    bail(acquiring);
    extTrigPin <= 1'b0;
    try(2'h1, 9'h000, 9'h000, 2'h1, 9'h002, 8'h00, 1'b1);
    try(2'h1, 9'h000, 9'h000, 2'h1, 9'h000, 8'h00, 1'b0);
    powerState <= 1'b0;
    tick(2);
    cmp("power", 1'b0, adcPowerUp);
    conclude;
  end
endmodule
